/* File: design/scan_check.v */
// Four channel analog scan sequencer with correction, filter, scale, checks
//
// Function
// - Each channel picks one of six ranges; processing follows that range.
// - Channels are acquired one at a time by stepping the mux select.
// - Amplifier gain is set from the channel range before conversion.
// - Each sample is a 24-bit word from the sigma-delta converter.
// - Raw samples get recalibration, alignment and self-calibration terms.
// - Corrected values pass a digital filter set per channel.
// - Filtered values are scaled to the per-channel output format.
// - Host supplies configuration; block returns values and status word.
// - Chain test, overflow test and watchdog faults are reported.
// - Normal cycle scans all channels in a constant 5 ms period.
// - Fast cycle scans in-use channels; period 1 ms plus 1 ms each.
// - Scan runs free of host cycle; host takes latest values.
// - Upper and lower tolerance flags are always evaluated.
// - With control on, flag overflow above and underflow below thresholds.
// - Live-zero ranges report an input error when the wire is open.
// - First-order filter, levels 0 to 6, 0 is off, changeable live.
// - Standard format: bipolar -10000..10000, unipolar 0..10000.
`timescale 1ns/1ps
`include "scan_check_defs.vh"

module scan_check #(
  parameter NUM_CH      = 4,
  parameter SLOT_CYCLES = `SLOT_CYCLES_CALC
) (
  // Clock and reset
  input  wire                   sys_clk,
  input  wire                   reset_n,
  // Module configuration
  input  wire                   fast_mode,
  input  wire [23:0]            self_cal_offset,
  input  wire [15:0]            self_cal_gain,
  // Channel configuration, channel n in slice n
  input  wire [3*NUM_CH-1:0]    chan_range,
  input  wire [NUM_CH-1:0]      chan_in_use,
  input  wire [NUM_CH-1:0]      chan_ovf_enable,
  input  wire [3*NUM_CH-1:0]    chan_filter_level,
  input  wire [NUM_CH-1:0]      chan_user_format,
  input  wire [16*NUM_CH-1:0]   chan_user_lo,
  input  wire [16*NUM_CH-1:0]   chan_user_hi,
  input  wire [16*NUM_CH-1:0]   chan_recal_offset,
  input  wire [16*NUM_CH-1:0]   chan_align_offset,
  // Front end and converter
  output reg  [1:0]             mux_sel,
  output reg  [2:0]             amp_gain_sel,
  output reg                    adc_start,
  input  wire [23:0]            adc_data,
  input  wire                   adc_valid,
  // Results to host
  output reg  [16*NUM_CH-1:0]   chan_value,
  output reg  [NUM_CH-1:0]      tol_high,
  output reg  [NUM_CH-1:0]      tol_low,
  output reg  [NUM_CH-1:0]      overflow,
  output reg  [NUM_CH-1:0]      underflow,
  output reg  [NUM_CH-1:0]      wire_error,
  output reg  [7:0]             module_status,
  output reg                    cycle_done
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_SETTLE = 3'h1;
  localparam ST_WAIT   = 3'h2;
  localparam ST_CORR   = 3'h3;
  localparam ST_FILT   = 3'h4;
  localparam ST_SCALE  = 3'h5;
  localparam ST_CHECK  = 3'h6;

  // Channel code meaning no channel left in this cycle
  localparam [2:0] CH_NONE = NUM_CH[2:0];

  // Per-channel configuration views
  wire [2:0]         rng_w   [0:NUM_CH-1];
  wire [2:0]         flt_w   [0:NUM_CH-1];
  wire signed [15:0] ulo_w   [0:NUM_CH-1];
  wire signed [15:0] uhi_w   [0:NUM_CH-1];
  wire signed [15:0] recal_w [0:NUM_CH-1];
  wire signed [15:0] align_w [0:NUM_CH-1];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : cfg
      assign rng_w[g]   = chan_range[3*g +: 3];
      assign flt_w[g]   = chan_filter_level[3*g +: 3];
      assign ulo_w[g]   = chan_user_lo[16*g +: 16];
      assign uhi_w[g]   = chan_user_hi[16*g +: 16];
      assign recal_w[g] = chan_recal_offset[16*g +: 16];
      assign align_w[g] = chan_align_offset[16*g +: 16];
    end
  endgenerate

  reg [31:0]        slot_cnt_reg;
  reg               house_reg;
  reg [1:0]         ch_reg;
  reg [2:0]         state_reg;
  reg [15:0]        settle_reg;
  reg signed [23:0] raw_reg;
  reg signed [23:0] corr_reg;
  reg signed [23:0] filt_mem [0:NUM_CH-1];
  reg [NUM_CH-1:0]  filt_init_reg;
  reg signed [18:0] std_reg;
  reg               chain_fault_reg;
  reg               wdog_fault_reg;

  wire slot_tick = (slot_cnt_reg == SLOT_CYCLES - 1);

  // Next channel to scan at or above index from, or NUM_CH when none remain
  function [2:0] next_ch;
    input [2:0]        from;
    input              fast;
    input [NUM_CH-1:0] use_mask;
    integer i;
    begin
      next_ch = CH_NONE;
      for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
        if (i >= from && (!fast || use_mask[i]))
          next_ch = i[2:0];
      end
    end
  endfunction

  wire [2:0] first_ch = next_ch(3'h0, fast_mode, chan_in_use);
  wire [2:0] after_ch = next_ch({1'b0, ch_reg} + 3'h1, fast_mode,
                                chan_in_use);
  wire [2:0] go_ch    = house_reg ? first_ch : after_ch;

  wire [2:0] cur_rng  = rng_w[ch_reg];
  wire       cur_bip  = (cur_rng == `RANGE_BIP_10V) ||
                        (cur_rng == `RANGE_BIP_5V) ||
                        (cur_rng == `RANGE_BIP_20MA);
  wire       cur_lz   = (cur_rng == `RANGE_LIVE_ZERO);
  wire [2:0] go_rng   = rng_w[go_ch[1:0]];

  // Correction datapath
  wire signed [24:0] cal_sum  = {raw_reg[23], raw_reg} +
                                {self_cal_offset[23], self_cal_offset};
  wire signed [41:0] cal_prod = cal_sum * $signed({1'b0, self_cal_gain});
  wire signed [27:0] cor_wide = cal_prod[41:14] +
                                {{12{recal_w[ch_reg][15]}}, recal_w[ch_reg]} +
                                {{12{align_w[ch_reg][15]}}, align_w[ch_reg]};
  wire signed [23:0] cor_sat  =
    (cor_wide > 28'sh07fffff) ? 24'sh7fffff :
    (cor_wide < -28'sh0800000) ? -24'sh800000 : cor_wide[23:0];

  // Filter datapath, alpha = 1 - 2^-(level+1)
  wire [2:0]         lvl      = (flt_w[ch_reg] > `FILT_MAX_LEVEL) ?
                                `FILT_MAX_LEVEL : flt_w[ch_reg];
  wire signed [23:0] filt_old = filt_mem[ch_reg];
  wire signed [24:0] filt_dif = {corr_reg[23], corr_reg} -
                                {filt_old[23], filt_old};
  wire signed [24:0] filt_stp = filt_dif >>> (lvl + 3'h1);
  wire signed [24:0] filt_sum = {filt_old[23], filt_old} + filt_stp;
  wire signed [23:0] filt_new =
    (lvl == 3'h0 || !filt_init_reg[ch_reg]) ? corr_reg : filt_sum[23:0];

  // Standardized scaling
  wire signed [24:0] sc_dif   = {filt_old[23], filt_old} -
                                (cur_lz ? `LIVE_ZERO_RAW : 25'sd0);
  wire signed [40:0] sc_prod  = sc_dif * (cur_lz ? `LZ_MULT : `STD_MULT);
  wire signed [18:0] sc_std   = sc_prod[40:22];

  // User scaling, lo + std * (hi - lo) / 10000
  wire signed [16:0] u_span   = {uhi_w[ch_reg][15], uhi_w[ch_reg]} -
                                {ulo_w[ch_reg][15], ulo_w[ch_reg]};
  wire signed [35:0] u_prod1  = std_reg * u_span;
  wire signed [50:0] u_prod2  = u_prod1 * `DIV_10000_MULT;
  wire signed [24:0] u_off    = u_prod2[50:26];
  wire signed [24:0] u_sum    = u_off + {{9{ulo_w[ch_reg][15]}},
                                         ulo_w[ch_reg]};
  wire signed [18:0] std_clp  =
    (std_reg > `STD_CLAMP_HI) ? `STD_CLAMP_HI :
    (std_reg < `STD_CLAMP_LO) ? `STD_CLAMP_LO : std_reg;
  wire signed [15:0] usr_clp  =
    (u_sum > 25'sd32767) ? 16'sh7fff :
    (u_sum < -25'sd32768) ? 16'sh8000 : u_sum[15:0];

  // Thresholds for the current range
  wire signed [18:0] nom_min  = cur_bip ? `NOM_MIN_BIP : `NOM_MIN_UNI;
  wire signed [18:0] ovf_hi   = cur_bip ? `BIP_OVF_HI :
                                cur_lz  ? `LZ_OVF_HI : `UNI_OVF_HI;
  wire signed [18:0] unf_lo   = cur_bip ? `BIP_UNF_LO :
                                cur_lz  ? `LZ_UNF_LO : `UNI_UNF_LO;

  integer k;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      slot_cnt_reg    <= 32'h0;
      house_reg       <= 1'b1;
      ch_reg          <= 2'h0;
      state_reg       <= ST_IDLE;
      settle_reg      <= 16'h0;
      raw_reg         <= 24'h0;
      corr_reg        <= 24'h0;
      std_reg         <= 19'h0;
      filt_init_reg   <= {NUM_CH{1'b0}};
      chain_fault_reg <= 1'b0;
      wdog_fault_reg  <= 1'b0;
      mux_sel         <= 2'h0;
      amp_gain_sel    <= 3'h0;
      adc_start       <= 1'b0;
      chan_value      <= {16*NUM_CH{1'b0}};
      tol_high        <= {NUM_CH{1'b0}};
      tol_low         <= {NUM_CH{1'b0}};
      overflow        <= {NUM_CH{1'b0}};
      underflow       <= {NUM_CH{1'b0}};
      wire_error      <= {NUM_CH{1'b0}};
      module_status   <= 8'h0;
      cycle_done      <= 1'b0;
      for (k = 0; k < NUM_CH; k = k + 1)
        filt_mem[k] <= 24'h0;
    end else begin
      adc_start  <= 1'b0;
      cycle_done <= 1'b0;
      slot_cnt_reg <= slot_tick ? 32'h0 : slot_cnt_reg + 32'h1;
      if (slot_tick) begin
        // Sample unfinished at slot end: converter did not answer
        if (state_reg != ST_IDLE && !house_reg)
          wdog_fault_reg <= 1'b1;
        state_reg <= ST_IDLE;
        if (go_ch == CH_NONE) begin
          // Housekeeping slot opens every cycle; normal mode always 5 slots
          if (!house_reg)
            cycle_done <= 1'b1;
          house_reg <= 1'b1;
        end else begin
          house_reg    <= 1'b0;
          ch_reg       <= go_ch[1:0];
          mux_sel      <= go_ch[1:0];
          amp_gain_sel <= {(go_rng == `RANGE_BIP_10V) ||
                           (go_rng == `RANGE_BIP_5V) ||
                           (go_rng == `RANGE_BIP_20MA),
                           (go_rng != `RANGE_BIP_10V) &&
                           (go_rng != `RANGE_UNI_10V),
                           (go_rng == `RANGE_BIP_20MA)};
          settle_reg   <= 16'h0;
          state_reg    <= ST_SETTLE;
        end
      end else begin
        case (state_reg)
          ST_SETTLE: begin
            settle_reg <= settle_reg + 16'h1;
            if (settle_reg == `SETTLE_CYCLES - 1) begin
              adc_start <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (adc_valid) begin
              raw_reg   <= adc_data;
              chain_fault_reg <= (adc_data == `ADC_SAT_POS) ||
                                 (adc_data == `ADC_SAT_NEG);
              wdog_fault_reg  <= 1'b0;
              state_reg <= ST_CORR;
            end
          end
          ST_CORR: begin
            corr_reg  <= cor_sat;
            state_reg <= ST_FILT;
          end
          ST_FILT: begin
            filt_mem[ch_reg]      <= filt_new;
            filt_init_reg[ch_reg] <= 1'b1;
            state_reg <= ST_SCALE;
          end
          ST_SCALE: begin
            std_reg   <= sc_std;
            state_reg <= ST_CHECK;
          end
          ST_CHECK: begin
            chan_value[16*ch_reg +: 16] <= chan_user_format[ch_reg] ?
                                           usr_clp : std_clp[15:0];
            tol_high[ch_reg]  <= (std_reg > `NOM_MAX);
            tol_low[ch_reg]   <= (std_reg < nom_min);
            overflow[ch_reg]  <= chan_ovf_enable[ch_reg] &&
                                 (std_reg > ovf_hi);
            underflow[ch_reg] <= chan_ovf_enable[ch_reg] &&
                                 (std_reg < unf_lo);
            wire_error[ch_reg] <= cur_lz &&
                                  (std_reg <= `OPEN_WIRE_STD);
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
      module_status <= {4'h0, fast_mode,
                        |(overflow | underflow | wire_error),
                        wdog_fault_reg, chain_fault_reg};
    end
  end

endmodule

/* File: design/scan_check_defs.vh */
// Constants for the four channel analog scan and check block
`ifndef SCAN_CHECK_DEFS_VH
`define SCAN_CHECK_DEFS_VH

// Clock and timing
`define CLK_FREQ_MHZ      20
`define SLOT_TIME_US      1000
`define SLOT_CYCLES_CALC  (`SLOT_TIME_US * `CLK_FREQ_MHZ)
`define NORMAL_PERIOD_MS  5
`define SLOT_TIME_MS      1
`define NORMAL_SLOTS      (`NORMAL_PERIOD_MS / `SLOT_TIME_MS)
`define SETTLE_TIME_US    50
`define SETTLE_CYCLES     (`SETTLE_TIME_US * `CLK_FREQ_MHZ)

// Range codes
`define RANGE_BIP_10V     3'h0
`define RANGE_UNI_10V     3'h1
`define RANGE_UNI_5V      3'h2
`define RANGE_LIVE_ZERO   3'h3
`define RANGE_BIP_5V      3'h4
`define RANGE_BIP_20MA    3'h5

// Amplifier gain select bit positions
`define GAIN_CURRENT_BIT  0
`define GAIN_SPAN5_BIT    1
`define GAIN_BIPOLAR_BIT  2

// Raw scaling: nominal full scale is 2^22 counts
`define FS_SHIFT          22
`define LIVE_ZERO_RAW     25'sd838861
`define STD_MULT          16'sd10000
`define LZ_MULT           16'sd12500
`define DIV_10000_MULT    15'sd6711
`define DIV_10000_SHIFT   26
`define GAIN_FRAC_BITS    14

// Standardized thresholds
`define NOM_MAX           (19'sd10000)
`define NOM_MIN_BIP       (-19'sd10000)
`define NOM_MIN_UNI       (19'sd0)
`define UNI_OVF_HI        (19'sd11000)
`define UNI_UNF_LO        (-19'sd1000)
`define LZ_OVF_HI         (19'sd10800)
`define LZ_UNF_LO         (-19'sd800)
`define BIP_OVF_HI        (19'sd11000)
`define BIP_UNF_LO        (-19'sd11000)
`define OPEN_WIRE_STD     (-19'sd4000)
`define STD_CLAMP_HI      (19'sd32767)
`define STD_CLAMP_LO      (-19'sd32768)

// Converter saturation codes seen as chain faults
`define ADC_SAT_POS       24'h7fffff
`define ADC_SAT_NEG       24'h800000

// Filter
`define FILT_MAX_LEVEL    3'h6

// Module status word bit positions
`define STAT_CHAIN_BIT    0
`define STAT_WDOG_BIT     1
`define STAT_CHERR_BIT    2
`define STAT_FAST_BIT     3

`endif

/* File: test/adc_model.sv */
// Behavioural sigma-delta converter that answers the scan block
`timescale 1ns/1ps
module adc_model (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         reset_n,
  // Request from the block
  input  wire         adc_start,
  input  wire [1:0]   mux_sel,
  // Bench controls
  input  wire [95:0]  sample_table,
  input  wire [7:0]   reply_delay,
  input  wire         mute,
  // Answer
  output logic [23:0] adc_data,
  output logic        adc_valid
);
  logic [7:0]  cnt_reg;
  logic        busy_reg;
  logic [23:0] last_reg = 24'h0;

  // Outside the answer cycle the data lines show the inverse of the last word
  always @(posedge sys_clk) begin
    adc_valid <= 1'b0;
    adc_data  <= ~last_reg;
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (adc_start && !mute) begin
      busy_reg <= 1'b1;
      cnt_reg  <= reply_delay;
    end else if (busy_reg && cnt_reg == 8'h0) begin
      busy_reg  <= 1'b0;
      adc_valid <= 1'b1;
      adc_data  <= sample_table[24*mux_sel +: 24];
      last_reg  <= sample_table[24*mux_sel +: 24];
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h1;
    end
  end
endmodule

/* File: test/scan_check_chk.sv */
// Port level checks for the scan and check block
`timescale 1ns/1ps
module scan_check_chk #(
  parameter SLOT_CYCLES = 1200
) (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset_n,
  // Configuration
  input wire        fast_mode,
  input wire [11:0] chan_range,
  input wire [3:0]  chan_in_use,
  input wire [3:0]  chan_ovf_enable,
  // Front end
  input wire [1:0]  mux_sel,
  input wire [2:0]  amp_gain_sel,
  input wire        adc_start,
  input wire        adc_valid,
  // Results
  input wire [63:0] chan_value,
  input wire [3:0]  tol_high,
  input wire [3:0]  tol_low,
  input wire [3:0]  overflow,
  input wire [3:0]  underflow,
  input wire [3:0]  wire_error,
  input wire [7:0]  module_status,
  input wire        cycle_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [1:0]  mux_q, last_ch;
  logic [11:0] quiet;
  logic [31:0] gap, gap_want;
  logic [4:0]  cfg_q;
  logic [3:0]  lz_mask;
  logic        wrapped, gap_ok;
  wire  [2:0]  rng = chan_range[3*mux_sel +: 3];
  wire  [2:0]  gain_want = {rng == 3'h0 || rng >= 3'h4, rng >= 3'h2,
                            rng == 3'h5};
  always @* begin
    gap_want = fast_mode ? (32'h1 + $countones(chan_in_use)) * SLOT_CYCLES
                         : 32'h5 * SLOT_CYCLES;
    for (int i = 0; i < 4; i++)
      lz_mask[i] = chan_range[3*i +: 3] == 3'h3;
  end
  // Cycle gap is trusted only once the scan set has stayed still a cycle
  always @(posedge sys_clk) begin
    mux_q <= mux_sel;
    cfg_q <= {fast_mode, chan_in_use};
    if (adc_start)
      last_ch <= mux_sel;
    if (!reset_n) begin
      quiet   <= 12'hfff;
      wrapped <= 1'b1;
      gap_ok  <= 1'b0;
      gap     <= 32'h0;
    end else begin
      quiet <= (mux_sel != mux_q) ? 12'h0 :
               (quiet == 12'hfff ? quiet : quiet + 12'h1);
      gap   <= cycle_done ? 32'h1 : gap + 32'h1;
      if (cycle_done)
        wrapped <= 1'b1;
      else if (adc_start)
        wrapped <= 1'b0;
      if (cfg_q != {fast_mode, chan_in_use})
        gap_ok <= 1'b0;
      else if (cycle_done)
        gap_ok <= 1'b1;
    end
  end
  sequence s_no_restart;
    !adc_start [*8];
  endsequence
  a_gain_from_range: assert property (
    adc_start |-> amp_gain_sel == gain_want)
    else $error("gain select does not match channel range");
  a_settle_time: assert property (
    adc_start && quiet < 12'd1100 |-> quiet inside {[12'd997:12'd1001]})
    else $error("start not one settle after mux");
  a_start_pulse: assert property (adc_start |=> s_no_restart)
    else $error("conversion start is not a lone pulse");
  a_ascending_order: assert property (
    adc_start && !wrapped |-> mux_sel > last_ch)
    else $error("channels not scanned in ascending order");
  a_fast_in_use: assert property (
    adc_start && fast_mode |-> chan_in_use[mux_sel])
    else $error("unused channel scanned in fast cycle");
  a_cycle_period: assert property (
    cycle_done && gap_ok |-> gap == gap_want)
    else $error("scan cycle length wrong");
  a_result_timing: assert property (
    $changed({chan_value, tol_high, tol_low, overflow, underflow,
              wire_error}) |-> $past(adc_valid, 5))
    else $error("results changed without a sample");
  a_ovf_enabled: assert property (
    ((overflow | underflow) & ~chan_ovf_enable) == 4'h0)
    else $error("overflow flag on a channel without control");
  a_ovf_in_tol: assert property (
    ((overflow & ~tol_high) | (underflow & ~tol_low)) == 4'h0)
    else $error("overflow flag without tolerance flag");
  a_wire_live_zero: assert property ((wire_error & ~lz_mask) == 4'h0)
    else $error("wire error on a range without live zero");
  a_status_errors: assert property (
    module_status[2] == $past(|{overflow, underflow, wire_error}))
    else $error("status error bit wrong");
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the scan and check block
`timescale 1ns/1ps
module tb_top;
  localparam SLOT = 1200;
  logic        sys_clk = 0, reset_n = 0, fast_mode = 0, mute = 0;
  logic [23:0] self_cal_offset = 24'h0;
  logic [15:0] self_cal_gain = 16'h4000;
  logic [11:0] chan_range = 12'hac8, chan_filter_level = 12'h0;
  logic [3:0]  chan_in_use = 4'hf, chan_ovf_enable = 4'h5;
  logic [3:0]  chan_user_format = 4'h0, visited;
  logic [63:0] chan_user_lo = 64'h0, chan_user_hi = 64'h0;
  logic [63:0] chan_recal_offset = 64'h0, chan_align_offset = 64'h0;
  logic [95:0] samples = 96'hc00000_000000_480000_480000;
  logic [7:0]  reply_delay = 8'h02;
  wire  [1:0]  mux_sel;
  wire  [2:0]  amp_gain_sel;
  wire  [23:0] adc_data;
  wire  [63:0] chan_value;
  wire  [3:0]  tol_high, tol_low, overflow, underflow, wire_error;
  wire  [7:0]  module_status;
  wire         adc_start, adc_valid, cycle_done;
  int          errors = 0, checks_done = 0, cycles = 0;

  scan_check #(.SLOT_CYCLES(SLOT)) u_scan_check (
    .sys_clk(sys_clk), .reset_n(reset_n), .fast_mode(fast_mode),
    .self_cal_offset(self_cal_offset), .self_cal_gain(self_cal_gain),
    .chan_range(chan_range), .chan_in_use(chan_in_use),
    .chan_ovf_enable(chan_ovf_enable), .chan_filter_level(chan_filter_level),
    .chan_user_format(chan_user_format), .chan_user_lo(chan_user_lo),
    .chan_user_hi(chan_user_hi), .chan_recal_offset(chan_recal_offset),
    .chan_align_offset(chan_align_offset), .mux_sel(mux_sel),
    .amp_gain_sel(amp_gain_sel), .adc_start(adc_start), .adc_data(adc_data),
    .adc_valid(adc_valid), .chan_value(chan_value), .tol_high(tol_high),
    .tol_low(tol_low), .overflow(overflow), .underflow(underflow),
    .wire_error(wire_error), .module_status(module_status),
    .cycle_done(cycle_done));
  adc_model u_adc_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .adc_start(adc_start),
    .mux_sel(mux_sel), .sample_table(samples), .reply_delay(reply_delay),
    .mute(mute), .adc_data(adc_data), .adc_valid(adc_valid));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (adc_start)
      visited[mux_sel] = 1'b1;
    if (cycles == 70000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wait_done(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      while (cycle_done !== 1'b1)
        @(posedge sys_clk);
    end
    #1;
  endtask
  // Expected value of one channel from its raw sample and configuration
  function automatic longint expect_std(input int ch);
    longint c, r;
    c = (($signed(samples[24*ch +: 24]) + $signed(self_cal_offset)) *
         $signed({1'b0, self_cal_gain})) >>> 14;
    c = c + $signed(chan_recal_offset[16*ch +: 16]) +
        $signed(chan_align_offset[16*ch +: 16]);
    c = c > 8388607 ? 8388607 : (c < -8388608 ? -8388608 : c);
    r = chan_range[3*ch +: 3];
    return r == 3 ? ((c - 838861) * 12500) >>> 22 : (c * 10000) >>> 22;
  endfunction
  task automatic check_all();
    longint s, v, hi, lo, r, ul, uh;
    for (int ch = 0; ch < 4; ch++) begin
      r  = chan_range[3*ch +: 3];
      s  = expect_std(ch);
      hi = r == 3 ? 10800 : 11000;
      lo = r == 3 ? -800 : (r == 1 || r == 2) ? -1000 : -11000;
      ul = $signed(chan_user_lo[16*ch +: 16]);
      uh = $signed(chan_user_hi[16*ch +: 16]);
      v  = chan_user_format[ch] ? ul + ((s * (uh - ul) * 6711) >>> 26) : s;
      check(chan_value[16*ch +: 16], v[15:0]);
      check(tol_high[ch], s > 10000);
      check(tol_low[ch], s < ((r >= 1 && r <= 3) ? 0 : -10000));
      check(overflow[ch], chan_ovf_enable[ch] && s > hi);
      check(underflow[ch], chan_ovf_enable[ch] && s < lo);
      check(wire_error[ch], r == 3 && s <= -4000);
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_done(1);
    check_all();
    // First order filter on channel 0 stepping from overrange to zero
    @(posedge sys_clk);
    chan_filter_level <= 12'h001;
    samples[23:0]     <= 24'h0;
    wait_done(2);
    check(chan_value[15:0], 16'd6328);
    @(posedge sys_clk);
    chan_filter_level <= 12'h0;
    chan_range        <= 12'had4;
    self_cal_gain     <= 16'h2000;
    self_cal_offset   <= 24'h000100;
    chan_recal_offset <= 64'h0010;
    chan_align_offset <= 64'h0000_0000_fff0_0000;
    samples           <= 96'h7fffff_c00000_480000_000000;
    chan_user_format  <= 4'h8;
    chan_user_lo      <= 64'h0c80_0000_0000_0000;
    chan_user_hi      <= 64'h2580_0000_0000_0000;
    wait_done(2);
    check_all();
    check(module_status, 8'h05);
    @(posedge sys_clk);
    fast_mode   <= 1'b1;
    chan_in_use <= 4'h5;
    reply_delay <= 8'd150;
    wait_done(2);
    visited = 4'h0;
    wait_done(1);
    check(visited, 4'h5);
    check(module_status[3], 1'b1);
    check_all();
    @(posedge sys_clk);
    mute <= 1'b1;
    wait_done(1);
    check(module_status[1], 1'b1);
    @(posedge sys_clk);
    mute <= 1'b0;
    wait_done(2);
    check(module_status[1], 1'b0);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(chan_value[31:0], 32'h0);
    check(chan_value[63:32], 32'h0);
    check({tol_high, tol_low, overflow, underflow, wire_error,
           module_status, cycle_done}, 32'h0);
    report_and_stop();
  end
endmodule

bind scan_check scan_check_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .fast_mode(fast_mode),
  .chan_range(chan_range), .chan_in_use(chan_in_use),
  .chan_ovf_enable(chan_ovf_enable), .mux_sel(mux_sel),
  .amp_gain_sel(amp_gain_sel), .adc_start(adc_start), .adc_valid(adc_valid),
  .chan_value(chan_value), .tol_high(tol_high), .tol_low(tol_low),
  .overflow(overflow), .underflow(underflow), .wire_error(wire_error),
  .module_status(module_status), .cycle_done(cycle_done));
